/* src/mmp_phy.sv */
/*
 * transceiver end of the mac port, with its receive elasticity fifo.
 * assumes line-side signals come from logic on core_clk; mac pins and
 * ref_clk come from outside and are synchronised here.
 */
`timescale 1ns/10ps
module mmp_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// Notes on behaviour
// - mode fixed by strap, not software
// - phy drives tx clock, mac launches
// - mac holds tx enable per nibble
// - mac raises tx error on errors, in mii mode only
// - phy drives rx data and clock
// - phy raises rx error on errors
// - rmii uses one reference clock
// - rmii carries both line rates
// - crs_dv rises at once on carrier
// - crs_dv falls only on nibble boundaries
// - tail toggles crs_dv per nibble
// - mac splits carrier and valid
// - false carrier keeps crs_dv up
// - rx dibits read 00 before data
// - all rmii pins timed to ref, except the crs_dv rise
// - rx data crosses elasticity fifo
// - rx error still driven in rmii
// - collision pin carries crs_dv
// - carrier sense follows duplex
// - collision when receiving during transmit, in half duplex mii only
module mmp_phy #(
    parameter int HALF_CYC = mmp_pkg::MII_HALF_CYC,
    parameter int FIFO_DEPTH = mmp_pkg::FIFO_DEPTH
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       mac_port_mode_strap,
    input  wire logic       speed_100,
    input  wire logic       duplex_full,
    input  wire logic [3:0] line_rx_data,
    input  wire logic       line_rx_err,
    input  wire logic       line_rx_valid,
    output logic            line_rx_ready,
    input  wire logic       line_carrier,
    output logic [3:0]      line_tx_data,
    output logic            line_tx_en,
    output logic            line_tx_err,
    output logic            mode_rmii,
    mmp_if.phy              pins
);
    if (HALF_CYC < 1) begin : g_chk
        $error("half period must be at least one cycle");
    end
    localparam int DIV_W = $clog2(HALF_CYC * mmp_pkg::RATE10_DIV + 1);

    // =====================================================================
    // synchronisers and strap
    logic [1:0] strap_s;
    logic       mode_done_q;
    logic [2:0] ref_s;
    logic [5:0] tx_s1;
    logic [5:0] tx_s2;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ref_s   <= '0;
            tx_s1   <= '0;
            tx_s2   <= '0;
        end else begin
            ref_s   <= {ref_s[1:0], pins.ref_clk};
            tx_s1   <= {pins.tx_er, pins.tx_en, pins.txd};
            tx_s2   <= tx_s1;
        end
    end

    // no reset: sync already full when reset ends
    always_ff @(posedge core_clk) begin
        strap_s <= {strap_s[0], mac_port_mode_strap};
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_done_q <= 1'b0;
            mode_rmii   <= mmp_pkg::MODE_MII;
        end else if (!mode_done_q) begin
            mode_done_q <= 1'b1;
            mode_rmii   <= strap_s[1];
        end
    end

    // =====================================================================
    // clock divider and step enables
    logic [DIV_W-1:0] div_q;
    logic             mii_clk_q;
    logic [3:0]       dec_q;
    logic             mii_rise;
    logic             mii_fall;
    logic             ref_rise;
    logic             rmii_step;
    logic [DIV_W-1:0] half_lim;

    // slower half period at 10 Mb/s
    assign half_lim = speed_100 ? DIV_W'(HALF_CYC - 1) : DIV_W'(HALF_CYC * mmp_pkg::RATE10_DIV - 1);
    assign mii_rise = (div_q == half_lim) & ~mii_clk_q;
    assign mii_fall = (div_q == half_lim) & mii_clk_q;
    assign ref_rise = ref_s[1] & ~ref_s[2];
    // one step per ten ref edges at 10 Mb/s, one per ref edge at 100 Mb/s
    assign rmii_step = ref_rise & (speed_100 | dec_q == 4'(mmp_pkg::RATE10_DIV - 1));

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q     <= '0;
            mii_clk_q <= 1'b0;
        end else if (div_q == half_lim) begin
            div_q     <= '0;
            mii_clk_q <= ~mii_clk_q;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dec_q <= '0;
        end else if (ref_rise) begin
            dec_q <= (speed_100 || dec_q == 4'(mmp_pkg::RATE10_DIV - 1)) ? 4'h0 : dec_q + 4'h1;
        end
    end

    assign pins.tx_clk = mii_clk_q;
    assign pins.rx_clk = mii_clk_q;

    // =====================================================================
    // receive path
    logic [4:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_pop;
    logic       rx_phase_q;
    logic [1:0] hi_q;
    logic [3:0] rxd_q;
    logic       dv_q;
    logic       er_q;
    logic       crs_dv_q;
    logic       carrier_prev_q;

    mmp_fifo #(
        .WIDTH (mmp_pkg::RX_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_data   ({line_rx_err, line_rx_data}),
        .in_valid  (line_rx_valid),
        .in_ready  (line_rx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign fifo_pop = fifo_valid & (mode_rmii ? (rmii_step & ~rx_phase_q) : mii_fall);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxd_q      <= '0;
            dv_q       <= 1'b0;
            er_q       <= 1'b0;
            rx_phase_q <= 1'b0;
            hi_q       <= '0;
        end else if (!mode_rmii && mii_fall) begin
            rxd_q <= fifo_valid ? fifo_data[3:0] : 4'h0;
            dv_q  <= fifo_valid;
            er_q  <= fifo_valid & fifo_data[4];
        end else if (mode_rmii && rmii_step) begin
            // rmii pins move on ref edges
            dv_q <= 1'b0;
            if (rx_phase_q) begin
                rxd_q      <= {2'b00, hi_q};
                rx_phase_q <= 1'b0;
            end else if (fifo_valid) begin
                rxd_q      <= {2'b00, fifo_data[1:0]};
                hi_q       <= fifo_data[3:2];
                er_q       <= fifo_data[4];
                rx_phase_q <= 1'b1;
            end else begin
                rxd_q <= 4'h0;
                er_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            carrier_prev_q <= 1'b0;
            crs_dv_q       <= 1'b0;
        end else begin
            carrier_prev_q <= line_carrier;
            if (rmii_step) begin
                crs_dv_q <= rx_phase_q ? 1'b1 : line_carrier;
            end else if (line_carrier && !carrier_prev_q) begin
                crs_dv_q <= 1'b1;
            end
        end
    end

    // =====================================================================
    // carrier sense and collision
    logic col_q;
    logic crs_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            col_q <= 1'b0;
            crs_q <= 1'b0;
        end else begin
            crs_q <= line_carrier | (tx_s2[4] & ~duplex_full);
            col_q <= ~duplex_full & line_carrier & tx_s2[4];
        end
    end

    assign pins.rxd   = rxd_q;
    assign pins.rx_dv = dv_q & ~mode_rmii;
    assign pins.rx_er = er_q;
    assign pins.crs   = crs_q & ~mode_rmii;
    assign pins.col_crs_dv = mode_rmii ? crs_dv_q : col_q;

    // =====================================================================
    // transmit path, no buffering
    logic       tx_phase_q;
    logic [1:0] tx_lo_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_tx_data <= '0;
            line_tx_en   <= 1'b0;
            line_tx_err  <= 1'b0;
            tx_phase_q   <= 1'b0;
            tx_lo_q      <= '0;
        end else if (!mode_rmii && mii_rise) begin
            line_tx_data <= tx_s2[3:0];
            line_tx_en   <= tx_s2[4];
            line_tx_err  <= tx_s2[5];
        end else if (mode_rmii && rmii_step) begin
            line_tx_err <= 1'b0;
            if (!tx_s2[4]) begin
                line_tx_en <= 1'b0;
                tx_phase_q <= 1'b0;
            end else if (!tx_phase_q) begin
                tx_lo_q    <= tx_s2[1:0];
                tx_phase_q <= 1'b1;
                line_tx_en <= 1'b0;
            end else begin
                line_tx_data <= {tx_s2[1:0], tx_lo_q};
                line_tx_en   <= 1'b1;
                tx_phase_q   <= 1'b0;
            end
        end else begin
            line_tx_en <= line_tx_en & ~mode_rmii;
        end
    end
endmodule

/* src/mmp_pkg.sv */
/*
 * constants shared by both ends of the mac port: pin widths, dividers,
 * fifo shape.
 * assumes one core clock of 10 MHz on both ends; link timing is scaled to it.
 */
package mmp_pkg;
    // =====================================================================
    // widths
    localparam int MII_W       = 4;
    localparam int RMII_W      = 2;
    localparam int RX_WORD_W   = 5;
    // =====================================================================
    // timing
    localparam int CORE_PERIOD_NS = 100;
    localparam int MII_PERIOD_NS  = 800;
    // scaled link clock, core cannot reach 25 MHz
    localparam int MII_HALF_CYC   = MII_PERIOD_NS / (2 * CORE_PERIOD_NS);
    localparam int RATE10_DIV     = 10;
    // =====================================================================
    // buffering and mode values
    localparam int FIFO_DEPTH  = 16;
    localparam logic MODE_MII  = 1'b0;
    localparam logic MODE_RMII = 1'b1;
endpackage

/* src/mmp_if.sv */
/*
 * pins between the transceiver end and the mac end.
 * assumes the bench drives ref_clk in rmii mode; all other nets have one driver.
 */
`timescale 1ns/10ps
interface mmp_if;
    logic       tx_clk;
    logic       rx_clk;
    logic       ref_clk;
    logic [3:0] txd;
    logic       tx_en;
    logic       tx_er;
    logic [3:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       col_crs_dv;
    logic       crs;

    modport phy (
        output tx_clk,
        output rx_clk,
        input  ref_clk,
        input  txd,
        input  tx_en,
        input  tx_er,
        output rxd,
        output rx_dv,
        output rx_er,
        output col_crs_dv,
        output crs
    );

    modport mac (
        input  tx_clk,
        input  rx_clk,
        input  ref_clk,
        output txd,
        output tx_en,
        output tx_er,
        input  rxd,
        input  rx_dv,
        input  rx_er,
        input  col_crs_dv,
        input  crs
    );
endinterface

/* src/mmp_mac.sv */
/*
 * mac end of the port: sends nibbles, recovers received nibbles.
 * assumes the port clocks and pins come from outside; all are synchronised.
 */
`timescale 1ns/10ps
module mmp_mac #(
    parameter int RATE_DIV = mmp_pkg::RATE10_DIV
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       mode_rmii,
    input  wire logic       speed_100,
    input  wire logic [3:0] tx_data,
    input  wire logic       tx_err,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic [3:0]      rx_data,
    output logic            rx_err,
    output logic            rx_valid,
    output logic            rx_carrier,
    output logic            col,
    mmp_if.mac              pins
);
    if (RATE_DIV < 2 || RATE_DIV > 15) begin : g_chk
        $error("rate divider out of range");
    end

    // =====================================================================
    // synchronisers and edges
    logic [2:0] txc_s;
    logic [2:0] rxc_s;
    logic [2:0] ref_s;
    logic [8:0] rx_s1;
    logic [8:0] rx_s2;
    logic [3:0] dec_q;
    logic       tx_step;
    logic       rx_step;
    logic       ref_rise;
    logic       rmii_step;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txc_s <= '0;
            rxc_s <= '0;
            ref_s <= '0;
            rx_s1 <= '0;
            rx_s2 <= '0;
        end else begin
            txc_s <= {txc_s[1:0], pins.tx_clk};
            rxc_s <= {rxc_s[1:0], pins.rx_clk};
            ref_s <= {ref_s[1:0], pins.ref_clk};
            rx_s1 <= {pins.crs, pins.col_crs_dv, pins.rx_er, pins.rx_dv, pins.rxd[1:0], pins.rxd[3:2], 1'b0};
            rx_s2 <= rx_s1;
        end
    end

    assign ref_rise  = ref_s[1] & ~ref_s[2];
    // 10 Mb/s samples once per ten
    assign rmii_step = ref_rise & (speed_100 | dec_q == 4'(RATE_DIV - 1));
    assign tx_step   = mode_rmii ? rmii_step : (txc_s[1] & ~txc_s[2]);
    assign rx_step   = mode_rmii ? rmii_step : (rxc_s[1] & ~rxc_s[2]);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dec_q <= '0;
        end else if (ref_rise) begin
            dec_q <= (speed_100 || dec_q == 4'(RATE_DIV - 1)) ? 4'h0 : dec_q + 4'h1;
        end
    end

    // =====================================================================
    // transmit
    logic       tx_phase_q;
    logic [1:0] tx_hi_q;
    logic [3:0] txd_q;
    logic       tx_en_q;
    logic       tx_er_q;
    assign tx_ready = tx_step & ~tx_phase_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txd_q      <= '0;
            tx_en_q    <= 1'b0;
            tx_er_q    <= 1'b0;
            tx_phase_q <= 1'b0;
            tx_hi_q    <= '0;
        end else if (tx_step) begin
            if (tx_phase_q) begin
                // second dibit on next ref step
                txd_q      <= {2'b00, tx_hi_q};
                tx_phase_q <= 1'b0;
            end else if (tx_valid) begin
                // launch on rising edge with enable
                txd_q      <= mode_rmii ? {2'b00, tx_data[1:0]} : tx_data;
                tx_hi_q    <= tx_data[3:2];
                tx_phase_q <= mode_rmii;
                tx_en_q    <= 1'b1;
                tx_er_q    <= tx_err & ~mode_rmii;
            end else begin
                txd_q   <= '0;
                tx_en_q <= 1'b0;
                tx_er_q <= 1'b0;
            end
        end
    end

    assign pins.txd   = txd_q;
    assign pins.tx_en = tx_en_q;
    assign pins.tx_er = tx_er_q;

    // =====================================================================
    // receive
    logic       started_q;
    logic       rx_phase_q;
    logic [1:0] lo_q;
    logic [1:0] d_lo;
    logic [1:0] d_hi;
    logic       crs_dv;
    assign d_lo   = rx_s2[4:3];
    assign d_hi   = rx_s2[2:1];
    assign crs_dv = rx_s2[7];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_data    <= '0;
            rx_err     <= 1'b0;
            rx_valid   <= 1'b0;
            rx_carrier <= 1'b0;
            col        <= 1'b0;
            started_q  <= 1'b0;
            rx_phase_q <= 1'b0;
            lo_q       <= '0;
        end else begin
            rx_valid <= 1'b0;
            col <= ~mode_rmii & rx_s2[7];
            if (!mode_rmii) begin
                rx_carrier <= rx_s2[8];
                if (rx_step && rx_s2[5]) begin
                    rx_data  <= {d_hi, d_lo};
                    rx_err   <= rx_s2[6];
                    rx_valid <= 1'b1;
                end
            end else if (rx_step) begin
                if (!started_q) begin
                    rx_carrier <= crs_dv;
                    if (crs_dv && d_lo != 2'b00) begin
                        lo_q       <= d_lo;
                        started_q  <= 1'b1;
                        rx_phase_q <= 1'b1;
                    end
                end else if (!rx_phase_q) begin
                    lo_q       <= d_lo;
                    rx_phase_q <= 1'b1;
                    rx_carrier <= crs_dv;
                end else if (crs_dv) begin
                    rx_data    <= {d_lo, lo_q};
                    rx_err     <= rx_s2[6];
                    rx_valid   <= 1'b1;
                    rx_phase_q <= 1'b0;
                end else begin
                    started_q  <= 1'b0;
                    rx_phase_q <= 1'b0;
                    rx_carrier <= 1'b0;
                end
            end
        end
    end
endmodule

/* tb/mmp_assertions.sv */
/*
 * pin checker for the mac port, one instance beside the interface.
 * assumes both ends share core_clk and rst; mode_rmii comes from the phy.
 */
`timescale 1ns/10ps
module mmp_assertions (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       mode_rmii,
    input wire logic       tx_clk,
    input wire logic       rx_clk,
    input wire logic [3:0] txd,
    input wire logic       tx_en,
    input wire logic [3:0] rxd,
    input wire logic       rx_dv,
    input wire logic       col_crs_dv,
    input wire logic       crs
);
    // =====================================================================
    // helper
    // edges since reset; the strap takes a few edges to settle
    logic [2:0] age_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    // =====================================================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_mode_held_stable: assert property (age_q > 3'h4 |-> $stable(mode_rmii))
        else $error("mode changed after reset");
    a_clocks_same: assert property (tx_clk == rx_clk)
        else $error("tx and rx clocks differ");
    a_clk_half_period: assert property ($rose(tx_clk) |-> tx_clk [*4] ##[1:37] !tx_clk)
        else $error("link clock half period out of range");
    a_rxd_stable_high: assert property (rx_dv && rx_clk && $past(rx_clk) |-> $stable(rxd))
        else $error("rx data moved while rx clock high");
    a_txd_stable_rise: assert property (!mode_rmii && $rose(tx_clk) |-> $stable(txd) && $stable(tx_en))
        else $error("tx data moved at tx clock rise");
    a_rmii_pins_low: assert property (mode_rmii |-> !rx_dv && !crs && rxd[3:2] == 2'h0 && txd[3:2] == 2'h0)
        else $error("unused pins active in reduced mode");
    a_col_needs_tx: assert property (!mode_rmii && !tx_en [*4] |=> !col_crs_dv)
        else $error("collision without transmit");
    a_col_means_crs: assert property (!mode_rmii && col_crs_dv |-> crs)
        else $error("collision without carrier sense");
endmodule

/* tb/mmp_tb.sv */
/*
 * bench joining both ends of the mac port through one interface.
 * assumes core_clk 100 ns and a free ref_clk of 800 ns made here.
 */
`timescale 1ns/10ps
module mmp_tb;
    // =====================================================================
    // signals
    logic       core_clk            = 1'b0;
    logic       rst                 = 1'b1;
    logic       mac_port_mode_strap = 1'b0;
    logic       speed_100           = 1'b1;
    logic       duplex_full         = 1'b0;
    logic [3:0] line_rx_data        = 4'h0;
    logic       line_rx_err         = 1'b0;
    logic       line_rx_valid       = 1'b0;
    logic       line_carrier        = 1'b0;
    logic [3:0] tx_data             = 4'h0;
    logic       tx_err              = 1'b0;
    logic       tx_valid            = 1'b0;
    logic       line_rx_ready, line_tx_en, line_tx_err, mode_rmii, tx_ready;
    logic       rx_err, rx_valid, rx_carrier, col, col_seen, crs_seen, refused;
    logic [3:0] line_tx_data, rx_data;
    logic [4:0] got_tx[$];
    logic [4:0] got_rx[$];
    int         tail_falls;
    int         num_errors          = 0;
    int         check_count         = 0;
    mmp_if u_mmp_if ();
    always #50 core_clk = ~core_clk;
    // ref clock runs free, phase unrelated to core_clk
    initial begin
        u_mmp_if.ref_clk = 1'b0;
        #137;
        forever #400 u_mmp_if.ref_clk = ~u_mmp_if.ref_clk;
    end
    mmp_phy u_mmp_phy (.core_clk(core_clk), .rst(rst), .mac_port_mode_strap(mac_port_mode_strap),
        .speed_100(speed_100), .duplex_full(duplex_full), .line_rx_data(line_rx_data),
        .line_rx_err(line_rx_err), .line_rx_valid(line_rx_valid), .line_rx_ready(line_rx_ready),
        .line_carrier(line_carrier), .line_tx_data(line_tx_data), .line_tx_en(line_tx_en),
        .line_tx_err(line_tx_err), .mode_rmii(mode_rmii), .pins(u_mmp_if));
    mmp_mac u_mmp_mac (.core_clk(core_clk), .rst(rst), .mode_rmii(mode_rmii), .speed_100(speed_100),
        .tx_data(tx_data), .tx_err(tx_err), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_err(rx_err), .rx_valid(rx_valid), .rx_carrier(rx_carrier), .col(col), .pins(u_mmp_if));
    mmp_assertions u_mmp_assertions (.core_clk(core_clk), .rst(rst), .mode_rmii(mode_rmii),
        .tx_clk(u_mmp_if.tx_clk), .rx_clk(u_mmp_if.rx_clk), .txd(u_mmp_if.txd), .tx_en(u_mmp_if.tx_en),
        .rxd(u_mmp_if.rxd), .rx_dv(u_mmp_if.rx_dv), .col_crs_dv(u_mmp_if.col_crs_dv), .crs(u_mmp_if.crs));
    // =====================================================================
    // monitors
    always @(posedge core_clk) begin
        if (rx_valid === 1'b1) got_rx.push_back({rx_err, rx_data});
        if (mode_rmii === 1'b1 && line_tx_en === 1'b1) got_tx.push_back({line_tx_err, line_tx_data});
        if (col === 1'b1) col_seen = 1'b1;
        if (u_mmp_if.crs === 1'b1) crs_seen = 1'b1;
        if (line_rx_valid === 1'b1 && line_rx_ready === 1'b0) refused = 1'b1;
    end
    // mii line side is a level; sample mid-period where it is settled
    always @(negedge u_mmp_if.tx_clk) begin
        if (mode_rmii === 1'b0 && line_tx_en === 1'b1) got_tx.push_back({line_tx_err, line_tx_data});
    end
    always @(negedge u_mmp_if.col_crs_dv) begin
        if (mode_rmii === 1'b1 && line_carrier === 1'b0) tail_falls++;
    end
    // =====================================================================
    // helpers
    function automatic logic [3:0] pat(input int i);
        return (i < 2) ? 4'h5 : 4'(i * 7 + 3);
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic start(input logic rmii, input logic fast, input logic full);
        @(posedge core_clk);
        rst <= 1'b1;
        mac_port_mode_strap <= rmii;
        speed_100 <= fast;
        duplex_full <= full;
        line_carrier <= 1'b0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        repeat (6) @(posedge core_clk);
        got_tx.delete();
        got_rx.delete();
        {col_seen, crs_seen, refused} = 3'h0;
        tail_falls = 0;
        check("mode", 8'(mode_rmii), 8'(rmii));
    endtask
    task automatic send_tx(input int n);
        for (int i = 0; i < n; i++) begin
            tx_valid <= 1'b1;
            tx_data <= pat(i);
            tx_err <= (i == 3);
            repeat (400) begin
                @(posedge core_clk);
                if (tx_ready === 1'b1) break;
            end
        end
        tx_valid <= 1'b0;
    endtask
    task automatic push_rx(input int n);
        for (int i = 0; i < n; i++) begin
            line_rx_valid <= 1'b1;
            line_rx_data <= pat(i);
            line_rx_err <= (i == 3);
            repeat (400) begin
                @(posedge core_clk);
                if (line_rx_ready === 1'b1) break;
            end
        end
        line_rx_valid <= 1'b0;
    endtask
    task automatic check_traffic(input int ntx, input int nrx, input logic rmii);
        repeat (20000) begin
            @(posedge core_clk);
            if (got_tx.size() >= ntx && got_rx.size() >= nrx) break;
        end
        repeat (50) @(posedge core_clk);
        check("tx count", 8'(got_tx.size()), 8'(ntx));
        check("rx count", 8'(got_rx.size()), 8'(nrx));
        // reduced mode does not carry tx error
        for (int i = 0; i < ntx; i++) check("tx nibble", 8'(got_tx[i]), {3'h0, i == 3 && !rmii, pat(i)});
        for (int i = 0; i < nrx; i++) check("rx nibble", 8'(got_rx[i]), {3'h0, i == 3, pat(i)});
    endtask
    // =====================================================================
    // scenarios
    task automatic test_mii_half();
        start(1'b0, 1'b1, 1'b0);
        line_carrier <= 1'b1;
        fork
            send_tx(8);
            push_rx(8);
        join
        check_traffic(8, 8, 1'b0);
        line_carrier <= 1'b0;
        check("collision", 8'(col_seen), 8'h01);
        $display("test mii_half done");
    endtask
    task automatic test_mii_full();
        start(1'b0, 1'b1, 1'b1);
        line_carrier <= 1'b1;
        fork
            send_tx(4);
            push_rx(4);
        join
        check_traffic(4, 4, 1'b0);
        line_carrier <= 1'b0;
        check("full collision", 8'(col_seen), 8'h00);
        $display("test mii_full done");
    endtask
    task automatic test_mii_slow_tx();
        start(1'b0, 1'b0, 1'b0);
        send_tx(4);
        check_traffic(4, 0, 1'b0);
        check("tx carrier", 8'(crs_seen), 8'h01);
        check("tx collision", 8'(col_seen), 8'h00);
        $display("test mii_slow_tx done");
    endtask
    task automatic test_rmii_fill();
        start(1'b1, 1'b1, 1'b0);
        line_carrier <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("early crs_dv", 8'(u_mmp_if.col_crs_dv), 8'h01);
        repeat (20) @(posedge core_clk);
        check("idle dibit", 8'(u_mmp_if.rxd), 8'h00);
        check("mac carrier", 8'(rx_carrier), 8'h01);
        fork
            send_tx(8);
            push_rx(20);
        join
        // carrier ends with the fifo still loaded, forcing the tail
        line_carrier <= 1'b0;
        check_traffic(8, 20, 1'b1);
        check("refused", 8'(refused), 8'h01);
        check("tail toggles", 8'(tail_falls > 1), 8'h01);
        check("carrier end", 8'(rx_carrier), 8'h00);
        $display("test rmii_fill done");
    endtask
    task automatic test_rmii_slow();
        start(1'b1, 1'b0, 1'b0);
        line_carrier <= 1'b1;
        fork
            send_tx(4);
            push_rx(4);
        join
        line_carrier <= 1'b0;
        check_traffic(4, 4, 1'b1);
        $display("test rmii_slow done");
    endtask
    // =====================================================================
    // main and watchdog
    initial begin
        test_mii_half();
        test_mii_full();
        test_mii_slow_tx();
        test_rmii_fill();
        test_rmii_slow();
        complete_run();
    end
    // all tests need well under 20000 cycles
    initial begin
        #4000000;
        num_errors++;
        complete_run();
    end
endmodule
